// ### hdl/alarm_hysteresis.v
// One temperature limit comparator with hysteresis release
`timescale 1ns/1ps
module alarm_hysteresis (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       update,
  input  wire [7:0] temp,
  input  wire [7:0] limit,
  input  wire [4:0] hyst,
  output reg        alarm
);
  wire [8:0] release_level;

  // Saturate at zero so a small limit cannot wrap to a huge release point
  assign release_level = ({1'b0, limit} > {4'h0, hyst}) ?
                         ({1'b0, limit} - {4'h0, hyst}) : 9'h000;

  always @(posedge clk) begin
    if (sys_rst) begin
      alarm <= 1'b0;
    end else if (update) begin
      if (temp > limit)
        alarm <= 1'b1;
      else if ({1'b0, temp} < release_level)
        alarm <= 1'b0;
    end
  end
endmodule

// ### hdl/conversion_scheduler.v
// Conversion timing: continuous, periodic and one-shot conversions
`timescale 1ns/1ps
`include "thermal_monitor_map.vh"
module conversion_scheduler #(
  parameter CONV_FAULT_CYC = `CONV_FAULT_US * `CLK_MHZ,
  parameter CONV_DIODE_CYC = `CONV_DIODE_US * `CLK_MHZ,
  parameter P364_CYC       = `PERIOD_364MS_US * `CLK_MHZ,
  parameter P1S_CYC        = `PERIOD_1S_US * `CLK_MHZ,
  parameter P2500_CYC      = `PERIOD_2500MS_US * `CLK_MHZ
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       enable,
  input  wire       standby,
  input  wire       one_shot,
  input  wire [1:0] rate,
  input  wire       diode_fault,
  output reg        busy,
  output reg        conv_done
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg  [1:0]  state;
  reg  [24:0] cnt;
  reg         from_shot;
  reg  [24:0] conv_len;
  reg  [24:0] period;

  always @* begin
    conv_len = diode_fault ? CONV_FAULT_CYC[24:0] : CONV_DIODE_CYC[24:0];
    case (rate)
      `RATE_364MS:  period = P364_CYC[24:0];
      `RATE_1S:     period = P1S_CYC[24:0];
      `RATE_2500MS: period = P2500_CYC[24:0];
      default:      period = conv_len;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      cnt       <= 25'h0000000;
      busy      <= 1'b0;
      conv_done <= 1'b0;
      from_shot <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          cnt <= 25'h0000000;
          if (enable && standby && one_shot) begin
            state     <= ST_CONV;
            busy      <= 1'b1;
            from_shot <= 1'b1;
          end else if (enable && !standby) begin
            state     <= ST_CONV;
            busy      <= 1'b1;
            from_shot <= 1'b0;
          end
        end
        ST_CONV: begin
          cnt <= cnt + 25'h0000001;
          // A started conversion always completes, even on entering standby
          if (cnt >= conv_len - 25'h0000001) begin
            busy      <= 1'b0;
            conv_done <= 1'b1;
            state     <= (from_shot || standby) ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt <= cnt + 25'h0000001;
          if (standby) begin
            state <= ST_IDLE;
          end else if (cnt >= period - 25'h0000001) begin
            cnt   <= 25'h0000000;
            state <= ST_CONV;
            busy  <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### hdl/thermal_monitor_control_regs.v
// Control, status and limit registers of the temperature monitor
//
// Behaviour
// - Config bits 4..1 mask remote crit, remote OT, local crit, local OT.
// - Config resets to zero; bits 7, 5, 0 read zero.
// - Config bit 6 high means standby, low means continual conversions.
// - A write to 0Fh in standby starts one conversion unless one is already running.
// - Rate bits 1:0 select continuous, 0.364, 1 or 2.5 s; reset 02h.
// - Continuous cycle is 33 ms with diode fault, 63 ms otherwise.
// - Config, rate and remote OT limit also reachable at alternate addresses.
// - Status bit 7 reads one while a conversion runs.
// - Status bit 4 shows the remote overtemperature alarm.
// - Status bit 1 shows the remote critical alarm.
// - Status bit 0 shows the shared local alarm.
// - Status bit 2 flags a missing or faulty remote diode.
// - On diode fault unsigned result reads 0, signed reads -128.
// - Status bits 6, 5 and 3 read zero.
// - Second status bit 7 reads one until 30 ms power-up ends.
// - Second status bit 6 free, bits 5..0 read zero.
// - Remote OT limit is unsigned 1 degree per count, reset 55h.
// - Local limit at 20h is shared by both local alarms, reset 55h.
// - Remote critical limit at 19h, unsigned, reset 6Eh.
// - Hysteresis at 21h holds 5 bits, upper bits zero, reset 0Ah.
`timescale 1ns/1ps
`include "thermal_monitor_map.vh"
module thermal_monitor_control_regs #(
  parameter CONV_FAULT_CYC = `CONV_FAULT_US * `CLK_MHZ,
  parameter CONV_DIODE_CYC = `CONV_DIODE_US * `CLK_MHZ,
  parameter P364_CYC       = `PERIOD_364MS_US * `CLK_MHZ,
  parameter P1S_CYC        = `PERIOD_1S_US * `CLK_MHZ,
  parameter P2500_CYC      = `PERIOD_2500MS_US * `CLK_MHZ,
  parameter POWER_UP_CYC   = `POWER_UP_US * `CLK_MHZ
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] remote_temp,
  input  wire [7:0] local_temp,
  input  wire       diode_fault_pin,
  output wire       conv_busy,
  output reg  [7:0] remote_unsigned_result,
  output reg  [7:0] remote_signed_result,
  output reg  [7:0] local_result,
  output reg        critical_alarm_output_n,
  output reg        overtemp_alarm_output_n
);
  reg  [7:0]  general_config;
  reg  [1:0]  conversion_period;
  reg  [7:0]  remote_overtemp_limit;
  reg  [7:0]  remote_critical_limit;
  reg  [7:0]  local_shared_limit;
  reg  [4:0]  shared_hysteresis;
  reg         fault_meta;
  reg         fault_sync;
  reg  [24:0] pwr_cnt;
  reg         not_ready;
  reg         one_shot;
  reg  [7:0]  next_rdata;

  wire        standby;
  wire        conv_done;
  wire [23:0] ch_temp;
  wire [23:0] ch_limit;
  wire [2:0]  ch_alarm;
  wire        remote_overtemp_flag;
  wire        remote_critical_flag;
  wire        local_alarm_flag;
  wire [7:0]  primary_status;
  wire [7:0]  secondary_status;

  wire wr_cfg;
  wire wr_rate;
  wire wr_rot;

  assign standby = general_config[`CFG_STANDBY_BIT];

  // both aliases decode to one register
  assign wr_cfg  = reg_wr && (reg_addr == `ADDR_GENERAL_CONFIG ||
                              reg_addr == `ADDR_GENERAL_CONFIG_ALT);
  assign wr_rate = reg_wr && (reg_addr == `ADDR_CONV_PERIOD ||
                              reg_addr == `ADDR_CONV_PERIOD_ALT);
  assign wr_rot  = reg_wr && (reg_addr == `ADDR_REMOTE_OT_LIMIT ||
                              reg_addr == `ADDR_REMOTE_OT_LIMIT_ALT);

  // Diode fault comes from the analog front end, outside this clock
  always @(posedge clk) begin
    if (sys_rst) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else begin
      fault_meta <= diode_fault_pin;
      fault_sync <= fault_meta;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pwr_cnt   <= 25'h0000000;
      not_ready <= 1'b1;
    end else if (not_ready) begin
      pwr_cnt <= pwr_cnt + 25'h0000001;
      if (pwr_cnt >= POWER_UP_CYC[24:0] - 25'h0000001)
        not_ready <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      general_config        <= `RST_GENERAL_CONFIG;
      conversion_period     <= `RST_CONV_PERIOD;
      remote_overtemp_limit <= `RST_REMOTE_OT_LIMIT;
      remote_critical_limit <= `RST_REMOTE_CRIT_LIMIT;
      local_shared_limit    <= `RST_LOCAL_SHARED_LIMIT;
      shared_hysteresis     <= `RST_SHARED_HYSTERESIS;
      one_shot              <= 1'b0;
    end else begin
      one_shot <= 1'b0;
      if (wr_cfg)
        general_config <= reg_wdata & `CFG_WRITABLE_MASK;
      if (wr_rate)
        conversion_period <= reg_wdata[1:0];
      if (wr_rot)
        remote_overtemp_limit <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_REMOTE_CRIT_LIMIT)
        remote_critical_limit <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_LOCAL_SHARED_LIMIT)
        local_shared_limit <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_SHARED_HYSTERESIS)
        shared_hysteresis <= reg_wdata[4:0];
      if (reg_wr && reg_addr == `ADDR_SINGLE_CONV_TRIGGER)
        one_shot <= 1'b1;
    end
  end

  // Conversions only start once the power-up sequence is over
  conversion_scheduler #(
    .CONV_FAULT_CYC (CONV_FAULT_CYC),
    .CONV_DIODE_CYC (CONV_DIODE_CYC),
    .P364_CYC       (P364_CYC),
    .P1S_CYC        (P1S_CYC),
    .P2500_CYC      (P2500_CYC)
  ) u_sched (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .enable      (~not_ready),
    .standby     (standby),
    .one_shot    (one_shot),
    .rate        (conversion_period),
    .diode_fault (fault_sync),
    .busy        (conv_busy),
    .conv_done   (conv_done)
  );

  // A faulty diode measures as zero degrees, so its remote alarms release
  assign ch_temp  = {local_temp,
                     fault_sync ? `FAULT_UNSIGNED_RESULT : remote_temp,
                     fault_sync ? `FAULT_UNSIGNED_RESULT : remote_temp};
  // one local limit serves both local alarms
  assign ch_limit = {local_shared_limit, remote_critical_limit,
                     remote_overtemp_limit};

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_ch
      alarm_hysteresis u_cmp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .update  (conv_done),
        .temp    (ch_temp[ch*8 +: 8]),
        .limit   (ch_limit[ch*8 +: 8]),
        .hyst    (shared_hysteresis),
        .alarm   (ch_alarm[ch])
      );
    end
  endgenerate

  assign remote_overtemp_flag = ch_alarm[`CH_REMOTE_OT];
  assign remote_critical_flag = ch_alarm[`CH_REMOTE_CRIT];
  assign local_alarm_flag     = ch_alarm[`CH_LOCAL];

  always @(posedge clk) begin
    if (sys_rst) begin
      remote_unsigned_result  <= `FAULT_UNSIGNED_RESULT;
      remote_signed_result    <= `FAULT_UNSIGNED_RESULT;
      local_result            <= `FAULT_UNSIGNED_RESULT;
      critical_alarm_output_n <= 1'b1;
      overtemp_alarm_output_n <= 1'b1;
    end else begin
      if (conv_done) begin
        local_result <= local_temp;
        if (fault_sync) begin
          remote_unsigned_result <= `FAULT_UNSIGNED_RESULT;
          remote_signed_result   <= `FAULT_SIGNED_RESULT;
        end else begin
          remote_unsigned_result <= remote_temp;
          // Signed range tops out at 127, so clamp rather than wrap
          remote_signed_result   <= remote_temp[7] ? `SIGNED_MAX_RESULT :
                                                     remote_temp;
        end
      end
      // a one in a mask bit silences that channel
      critical_alarm_output_n <= ~(
        (remote_critical_flag &
         ~general_config[`CFG_REMOTE_CRIT_MASK_BIT]) |
        (local_alarm_flag &
         ~general_config[`CFG_LOCAL_CRIT_MASK_BIT]));
      overtemp_alarm_output_n <= ~(
        (remote_overtemp_flag &
         ~general_config[`CFG_REMOTE_OT_MASK_BIT]) |
        (local_alarm_flag &
         ~general_config[`CFG_LOCAL_OT_MASK_BIT]));
    end
  end

  assign primary_status = {conv_busy, 2'b00, remote_overtemp_flag, 1'b0,
                           fault_sync, remote_critical_flag,
                           local_alarm_flag};
  assign secondary_status = {not_ready, 7'h00};

  always @* begin
    case (reg_addr)
      `ADDR_PRIMARY_STATUS:      next_rdata = primary_status;
      `ADDR_GENERAL_CONFIG,
      `ADDR_GENERAL_CONFIG_ALT:  next_rdata = general_config;
      `ADDR_CONV_PERIOD,
      `ADDR_CONV_PERIOD_ALT:     next_rdata = {6'h00, conversion_period};
      `ADDR_REMOTE_OT_LIMIT,
      `ADDR_REMOTE_OT_LIMIT_ALT: next_rdata = remote_overtemp_limit;
      `ADDR_REMOTE_CRIT_LIMIT:   next_rdata = remote_critical_limit;
      `ADDR_LOCAL_SHARED_LIMIT:  next_rdata = local_shared_limit;
      `ADDR_SHARED_HYSTERESIS:   next_rdata = {3'h0, shared_hysteresis};
      `ADDR_SECONDARY_STATUS:    next_rdata = secondary_status;
      // Write-only trigger and unmapped addresses read zero
      default:                   next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule

// ### hdl/thermal_monitor_map.vh
// Register map, field positions, reset values and timing of the monitor
`ifndef THERMAL_MONITOR_MAP_VH
`define THERMAL_MONITOR_MAP_VH

// Register offsets (byte addresses on the register port)
`define ADDR_PRIMARY_STATUS      8'h02
`define ADDR_GENERAL_CONFIG      8'h03
`define ADDR_GENERAL_CONFIG_ALT  8'h09
`define ADDR_CONV_PERIOD         8'h04
`define ADDR_CONV_PERIOD_ALT     8'h0a
`define ADDR_REMOTE_OT_LIMIT     8'h07
`define ADDR_REMOTE_OT_LIMIT_ALT 8'h0d
`define ADDR_SINGLE_CONV_TRIGGER 8'h0f
`define ADDR_REMOTE_CRIT_LIMIT   8'h19
`define ADDR_LOCAL_SHARED_LIMIT  8'h20
`define ADDR_SHARED_HYSTERESIS   8'h21
`define ADDR_SECONDARY_STATUS    8'h33

// Reset values
`define RST_GENERAL_CONFIG       8'h00
`define RST_CONV_PERIOD          2'h2
`define RST_REMOTE_OT_LIMIT      8'h55
`define RST_REMOTE_CRIT_LIMIT    8'h6e
`define RST_LOCAL_SHARED_LIMIT   8'h55
`define RST_SHARED_HYSTERESIS    5'h0a

// general_config fields
`define CFG_STANDBY_BIT          6
`define CFG_REMOTE_CRIT_MASK_BIT 4
`define CFG_REMOTE_OT_MASK_BIT   3
`define CFG_LOCAL_CRIT_MASK_BIT  2
`define CFG_LOCAL_OT_MASK_BIT    1
`define CFG_WRITABLE_MASK        8'h5e

// primary_status fields
`define STAT_BUSY_BIT            7
`define STAT_REMOTE_OT_BIT       4
`define STAT_DIODE_FAULT_BIT     2
`define STAT_REMOTE_CRIT_BIT     1
`define STAT_LOCAL_BIT           0

// secondary_status fields
`define STAT2_NOT_READY_BIT      7

// Conversion rate codes
`define RATE_CONTINUOUS          2'h0
`define RATE_364MS               2'h1
`define RATE_1S                  2'h2
`define RATE_2500MS              2'h3

// Result values forced while the remote diode is faulty, and the signed clamp value
`define FAULT_UNSIGNED_RESULT    8'h00
`define FAULT_SIGNED_RESULT      8'h80
`define SIGNED_MAX_RESULT        8'h7f

// Times in microseconds and the clock rate in MHz
`define CLK_MHZ                  10
`define CONV_FAULT_US            33000
`define CONV_DIODE_US            63000
`define PERIOD_364MS_US          364000
`define PERIOD_1S_US             1000000
`define PERIOD_2500MS_US         2500000
`define POWER_UP_US              30000

// Channel indices of the alarm comparators
`define CH_REMOTE_OT             0
`define CH_REMOTE_CRIT           1
`define CH_LOCAL                 2
`define NUM_CH                   3

`endif

// ### tb/host_model.sv
// Register-port host issuing single-byte writes and reads
`timescale 1ns/1ps
module host_model (
  input  wire        clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  input  wire  [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so a stale address is never reused
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ### tb/tb_thermal_monitor_control_regs.sv
// Self-checking bench for the monitor register set
`timescale 1ns/1ps
module tb_thermal_monitor_control_regs;
  logic        clk;
  logic        sys_rst;
  wire  [7:0]  reg_addr;
  wire         reg_wr;
  wire  [7:0]  reg_wdata;
  wire         reg_rd;
  wire  [7:0]  reg_rdata;
  logic [7:0]  remote_temp;
  logic [7:0]  local_temp;
  logic        diode_fault_pin;
  wire         conv_busy;
  wire  [7:0]  remote_unsigned_result;
  wire  [7:0]  remote_signed_result;
  wire  [7:0]  local_result;
  wire         critical_alarm_output_n;
  wire         overtemp_alarm_output_n;
  int          err_count;
  int          cmp_count;
  int          cur_len = 0;
  int          last_len = 0;
  int          runs = 0;
  int          runs_seen;
  localparam int CONV_FAULT = 20;
  localparam int CONV_DIODE = 30;
  localparam int P364       = 60;
  localparam int P1S        = 80;
  localparam int P2500      = 100;
  localparam int PWR_UP     = 10;
  logic [7:0]  rd;
  logic [32:0] rows [0:19];
  thermal_monitor_control_regs #(.CONV_FAULT_CYC(CONV_FAULT),
    .CONV_DIODE_CYC(CONV_DIODE), .P364_CYC(P364), .P1S_CYC(P1S),
    .P2500_CYC(P2500), .POWER_UP_CYC(PWR_UP))
    thermal_monitor_control_regs_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .remote_temp(remote_temp), .local_temp(local_temp),
    .diode_fault_pin(diode_fault_pin), .conv_busy(conv_busy),
    .remote_unsigned_result(remote_unsigned_result),
    .remote_signed_result(remote_signed_result), .local_result(local_result),
    .critical_alarm_output_n(critical_alarm_output_n),
    .overtemp_alarm_output_n(overtemp_alarm_output_n));
  host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Length of the last completed busy run, in clock cycles
  always @(posedge clk) begin
    if (conv_busy === 1'b1)
      cur_len <= cur_len + 1;
    else if (cur_len != 0) begin
      last_len <= cur_len;
      cur_len <= 0;
      runs <= runs + 1;
    end
  end
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_model_i.read_reg(a, rd);
    check("register read", {8'h00, rd}, {8'h00, e});
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        err_count++;
        $display("ERROR conv_busy expected %b seen timeout", lvl);
        print_verdict();
      end
    end
  endtask
  task automatic one_conv(input int len);
    host_model_i.write_reg(8'h0f, 8'h5a);
    wait_busy(1'b1);
    host_model_i.read_reg(8'h02, rd);
    check("busy bit", {8'h00, rd & 8'h80}, 16'h0080);
    wait_busy(1'b0);
    repeat (3) @(posedge clk);
    #1;
    check("conv length", last_len[15:0], len[15:0]);
  endtask
  // Skips one start so a rate change has settled before measuring
  task automatic gap(input int exp);
    int n;
    bit low;
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    wait_busy(1'b1);
    n = 0;
    low = 0;
    while (!(low && conv_busy === 1'b1) && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      if (conv_busy === 1'b0)
        low = 1;
    end
    check("start gap", n[15:0], exp[15:0]);
  endtask
  task automatic alarms(input logic crit_n, input logic ot_n);
    check("crit out", {15'h0, critical_alarm_output_n}, {15'h0, crit_n});
    check("ot out", {15'h0, overtemp_alarm_output_n}, {15'h0, ot_n});
  endtask
  initial begin
    sys_rst = 1'b1;
    remote_temp = 8'h00;
    local_temp = 8'h00;
    diode_fault_pin = 1'b0;
    err_count = 0;
    cmp_count = 0;
    rows = '{33'h0_0000_0300, 33'h0_0000_0900, 33'h0_0000_0402,
      33'h0_0000_0a02, 33'h0_0000_0755, 33'h0_0000_0d55, 33'h0_0000_196e,
      33'h0_0000_2055, 33'h0_0000_210a, 33'h0_0000_0f00, 33'h0_0000_4000,
      33'h1_09ff_035e, 33'h1_0aff_0403, 33'h1_07c8_0dc8, 33'h1_19ff_19ff,
      33'h1_2000_2000, 33'h1_21ff_211f, 33'h1_40a5_4000, 33'h1_33ff_3300,
      33'h1_0300_0900};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][32])
        host_model_i.write_reg(rows[i][31:24], rows[i][23:16]);
      host_model_i.read_reg(rows[i][15:8], rd);
      check("row", {8'h00, rd}, {8'h00, rows[i][7:0]});
    end
    $display("Register table test done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(8'h33, 8'h80);
    host_model_i.write_reg(8'h03, 8'h40);
    rdchk(8'h07, 8'h55);
    repeat (12) @(posedge clk);
    rdchk(8'h33, 8'h00);
    $display("Reset test done");
    host_model_i.write_reg(8'h07, 8'h50);
    host_model_i.write_reg(8'h19, 8'h60);
    host_model_i.write_reg(8'h20, 8'h40);
    host_model_i.write_reg(8'h21, 8'h05);
    @(posedge clk);
    remote_temp <= 8'h70;
    local_temp <= 8'h45;
    one_conv(30);
    rdchk(8'h02, 8'h13);
    alarms(1'b0, 1'b0);
    check("unsigned", {8'h00, remote_unsigned_result}, 16'h0070);
    check("signed", {8'h00, remote_signed_result}, 16'h0070);
    check("local", {8'h00, local_result}, 16'h0045);
    host_model_i.write_reg(8'h03, 8'h54);
    one_conv(30);
    rdchk(8'h02, 8'h13);
    alarms(1'b1, 1'b0);
    host_model_i.write_reg(8'h03, 8'h4a);
    one_conv(30);
    alarms(1'b0, 1'b1);
    host_model_i.write_reg(8'h03, 8'h40);
    @(posedge clk);
    remote_temp <= 8'h4c;
    local_temp <= 8'h3c;
    one_conv(30);
    rdchk(8'h02, 8'h11);
    @(posedge clk);
    remote_temp <= 8'h4a;
    local_temp <= 8'h3a;
    one_conv(30);
    rdchk(8'h02, 8'h00);
    alarms(1'b1, 1'b1);
    $display("Alarm test done");
    @(posedge clk);
    diode_fault_pin <= 1'b1;
    remote_temp <= 8'h70;
    repeat (4) @(posedge clk);
    one_conv(20);
    rdchk(8'h02, 8'h04);
    check("fault unsigned", {8'h00, remote_unsigned_result}, 16'h0000);
    check("fault signed", {8'h00, remote_signed_result}, 16'h0080);
    host_model_i.write_reg(8'h0f, 8'h00);
    host_model_i.write_reg(8'h0f, 8'h00);
    wait_busy(1'b1);
    wait_busy(1'b0);
    // Let the finished run be counted before taking the reference
    repeat (2) @(posedge clk);
    runs_seen = runs;
    repeat (40) @(posedge clk);
    check("extra conversion", 16'(runs - runs_seen), 16'h0000);
    $display("One-shot test done");
    host_model_i.write_reg(8'h03, 8'h00);
    host_model_i.write_reg(8'h0a, 8'h00);
    gap(CONV_FAULT + 1);
    @(posedge clk);
    diode_fault_pin <= 1'b0;
    gap(CONV_DIODE + 1);
    for (int r = 1; r < 4; r++) begin
      host_model_i.write_reg(8'h04, r[7:0]);
      // Periodic rates repeat start to start after exactly one period
      gap(r == 1 ? P364 : (r == 2 ? P1S : P2500));
    end
    host_model_i.write_reg(8'h03, 8'h40);
    $display("Rate test done");
    print_verdict();
  end
endmodule
bind thermal_monitor_control_regs thermal_monitor_properties #(
  .CONV_FAULT_CYC(CONV_FAULT_CYC), .CONV_DIODE_CYC(CONV_DIODE_CYC),
  .POWER_UP_CYC(POWER_UP_CYC)) props_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .diode_fault_pin(diode_fault_pin), .conv_busy(conv_busy),
  .remote_unsigned_result(remote_unsigned_result),
  .remote_signed_result(remote_signed_result),
  .critical_alarm_output_n(critical_alarm_output_n),
  .overtemp_alarm_output_n(overtemp_alarm_output_n));

// ### tb/thermal_monitor_properties.sv
// Concurrent checks on the register port and conversion outputs
`timescale 1ns/1ps
module thermal_monitor_properties #(
  parameter CONV_FAULT_CYC = 20,
  parameter CONV_DIODE_CYC = 30,
  parameter POWER_UP_CYC   = 10
) (
  input wire       clk,
  input wire       sys_rst,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       diode_fault_pin,
  input wire       conv_busy,
  input wire [7:0] remote_unsigned_result,
  input wire [7:0] remote_signed_result,
  input wire       critical_alarm_output_n,
  input wire       overtemp_alarm_output_n
);
  reg [15:0] up_cnt;
  reg [15:0] run_cnt;
  reg        standby;
  always @(posedge clk) begin
    if (sys_rst) begin
      up_cnt <= 16'h0000;
      run_cnt <= 16'h0000;
      standby <= 1'b0;
    end else begin
      if (up_cnt != 16'hffff)
        up_cnt <= up_cnt + 16'h0001;
      run_cnt <= conv_busy ? run_cnt + 16'h0001 : 16'h0000;
      if (reg_wr && (reg_addr == 8'h03 || reg_addr == 8'h09))
        standby <= reg_wdata[6];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_busy_length:
    assert property ($fell(conv_busy) && !$past(sys_rst)
      |-> run_cnt == CONV_DIODE_CYC
      || run_cnt == CONV_FAULT_CYC) else $error("conversion length wrong");
  a_cfg_reserved:
    assert property (reg_rd && (reg_addr == 8'h03 || reg_addr == 8'h09)
      |=> (reg_rdata & 8'ha1) == 8'h00) else $error("config reserved set");
  a_rate_reserved:
    assert property (reg_rd && (reg_addr == 8'h04 || reg_addr == 8'h0a)
      |=> reg_rdata[7:2] == 6'h00) else $error("rate upper bits set");
  a_status_reserved:
    assert property (reg_rd && reg_addr == 8'h02
      |=> (reg_rdata & 8'h68) == 8'h00) else $error("status reserved set");
  a_hyst_upper:
    assert property (reg_rd && reg_addr == 8'h21
      |=> reg_rdata[7:5] == 3'h0) else $error("hysteresis upper bits set");
  a_status2_low:
    assert property (reg_rd && reg_addr == 8'h33
      |=> reg_rdata[5:0] == 6'h00) else $error("status2 low bits set");
  a_notready_read:
    assert property (reg_rd && reg_addr == 8'h33 && up_cnt < POWER_UP_CYC - 2
      |=> reg_rdata[7]) else $error("not ready bit low too early");
  a_powerup_quiet:
    assert property (up_cnt < POWER_UP_CYC |-> !conv_busy)
      else $error("conversion during power-up");
  a_oneshot_start:
    assert property (reg_wr && reg_addr == 8'h0f && standby && !conv_busy
      && up_cnt > POWER_UP_CYC + 4 |-> ##[1:3] conv_busy)
      else $error("one-shot did not start");
  a_fault_results:
    assert property ($fell(conv_busy) && diode_fault_pin
      && $past(diode_fault_pin, 4) |=> remote_unsigned_result == 8'h00
      && remote_signed_result == 8'h80) else $error("fault results wrong");
  c_oneshot: cover property (reg_wr && reg_addr == 8'h0f && standby);
  c_fault_end: cover property ($fell(conv_busy) && diode_fault_pin);
  c_both_alarms: cover property (!critical_alarm_output_n
    && !overtemp_alarm_output_n);
endmodule
